//--- include/flash_rd_pkg.sv
// constants shared by both ends of the serial array read link
// assumes a host that makes the serial clock and a device clocked by it
// Contract
// [R1] legacy read: opcode, address, four dummies
// [R2] fastest read: opcode, address, two dummies
// [R3] fast read: opcode, address, one dummy
// [R4] slow read: data right after address
// [R5] 264 mode: 11 page, 9 byte bits
// [R6] 256 mode: 11 page, 8 byte bits
// [R7] address counter advances itself during read
// [R8] each later clock shifts next data bit
// [R9] host keeps select low whole command
// [R10] page end runs into next page
// [R11] array end wraps to page zero
// [R12] select rising ends read, output released
// [R13] reads come from array, buffers untouched
// [R14] host avoids the legacy read opcode; this host still issues it when asked
// [R15] no-dummy opcode only at slow clock
// [R16] command starts with select fall, opcode
// [R17] everything shifts most significant bit first
// [R18] device works in clock modes 0 and 3
// [R19] unused high address bits are ignored
// [R20] dummy bits counted, never interpreted
package flash_rd_pkg;
   localparam logic [7:0] OP_LEGACY = 8'hE8;
   localparam logic [7:0] OP_FASTEST = 8'h1B;
   localparam logic [7:0] OP_FAST = 8'h0B;
   localparam logic [7:0] OP_SLOW = 8'h03;
   // header lengths in serial bits: opcode + address + dummies
   localparam logic [6:0] HDR_LEGACY = 7'h40;
   localparam logic [6:0] HDR_FASTEST = 7'h30;
   localparam logic [6:0] HDR_FAST = 7'h28;
   localparam logic [6:0] HDR_SLOW = 7'h20;
   localparam logic [6:0] HDR_NONE = 7'h00;
   localparam int PAGE_W = 11;
   localparam int BYTE_W = 9;
   localparam logic [8:0] LAST_BYTE_264 = 9'h107;
   localparam logic [8:0] LAST_BYTE_256 = 9'h0FF;
   localparam int TX_W = 64;
   localparam int HALF_PERIOD = 4;

   // serial bits before the first data bit; zero marks an unknown opcode
   function automatic logic [6:0] hdr_bits(input logic [7:0] op);
      logic [6:0] r;
      case (op)
         OP_LEGACY: r = HDR_LEGACY; // [R1]
         OP_FASTEST: r = HDR_FASTEST; // [R2]
         OP_FAST: r = HDR_FAST; // [R3]
         OP_SLOW: r = HDR_SLOW; // [R4]
         default: r = HDR_NONE;
      endcase
      return r;
   endfunction : hdr_bits
endpackage : flash_rd_pkg

//--- include/flash_link_if.sv
// serial link between read host and flash device
// assumes the bench joins one host and one device through it
`timescale 1ns/1ns
interface flash_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic so_line;

   // released line reads high, as with a pull-up
   assign so_line = so_oe ? so : 1'b1;

   modport dev (input cs_n, input sck, input si, output so, output so_oe);
   modport host (output cs_n, output sck, output si, input so_line);
endinterface : flash_link_if

//--- logic/sync2.sv
// two-flop level synchroniser
// assumes an asynchronous active-low reset on the destination clock
`timescale 1ns/1ns
module sync2
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_ff;
   logic q_ff;

   // first flop feeds only the second
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_ff <= 1'b0;
         q_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= d_i;
         q_ff <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule : sync2

//--- logic/flash_rd_dev.sv
// device end: decodes continuous array reads and streams array data
// assumes the array answers combinationally to the page and byte outputs
`timescale 1ns/1ns
module flash_rd_dev
(
   flash_link_if.dev LNK,
   input wire logic RST_N_I,
   input wire logic PAGE_264_I,
   input wire logic [7:0] ARR_DATA_I,
   output logic [flash_rd_pkg::PAGE_W-1:0] ARR_PAGE_O,
   output logic [flash_rd_pkg::BYTE_W-1:0] ARR_BYTE_O,
   output logic READ_ACTIVE_O
);
   ////////////////////////////////////////////////////////////////////////
   // types

   // state sampled on the rising serial clock
   typedef struct packed {
      logic [6:0] cnt;
      logic [31:0] sh;
   } rise_t;

   // state updated on the falling serial clock
   typedef struct packed {
      logic run;
      logic [flash_rd_pkg::PAGE_W-1:0] page;
      logic [flash_rd_pkg::BYTE_W-1:0] byte_ix;
      logic [2:0] bitx;
      logic so;
   } fall_t;

   typedef struct packed {
      logic [flash_rd_pkg::PAGE_W-1:0] page;
      logic [flash_rd_pkg::BYTE_W-1:0] byte_ix;
   } loc_t;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // split the address field by page mode
   function automatic loc_t map_addr(input logic [23:0] a,
                                     input logic m264);
      loc_t r;
      if (m264)
      begin
         r.page = a[19:9]; // [R5]
         r.byte_ix = a[8:0]; // [R5]
      end
      else
      begin
         r.page = a[18:8]; // [R6]
         r.byte_ix = {1'b0, a[7:0]}; // [R6]
      end
      // a[23:20] or a[23:19] are never looked at [R19]
      return r;
   endfunction : map_addr

   // next array location: page end runs on, array end wraps
   function automatic loc_t step_addr(input loc_t l, input logic m264);
      loc_t r;
      logic [flash_rd_pkg::BYTE_W-1:0] last;
      last = m264 ? flash_rd_pkg::LAST_BYTE_264
                  : flash_rd_pkg::LAST_BYTE_256;
      r = l;
      if (l.byte_ix >= last)
      begin
         r.byte_ix = '0; // [R10]
         // page field overflows back to page zero [R11]
         r.page = l.page + 1'b1;
      end
      else
      begin
         r.byte_ix = l.byte_ix + 1'b1; // [R7]
      end
      return r;
   endfunction : step_addr

   ////////////////////////////////////////////////////////////////////////
   // link reset and configuration crossing

   logic lnk_rst_n;
   logic m264;
   rise_t rise_ff;
   rise_t nxt_rise;
   fall_t fall_ff;
   fall_t nxt_fall;
   logic [6:0] hdr_len;
   logic hdr_done;
   loc_t start_loc;
   loc_t cur_loc;
   loc_t adv_loc;

   // a high select clears the rise and fall state flops, since the clock may stop; the mode synchroniser keeps RST_N_I
   assign lnk_rst_n = RST_N_I & ~LNK.cs_n; // [R12]

   // page mode is a static strap from outside the link clock
   sync2 u_mode_sync
   (
      .clk_i(LNK.sck),
      .rst_n_i(RST_N_I),
      .d_i(PAGE_264_I),
      .q_o(m264)
   );

   ////////////////////////////////////////////////////////////////////////
   // header capture on the rising edge

   assign hdr_len = flash_rd_pkg::hdr_bits(rise_ff.sh[31:24]);
   assign hdr_done = (rise_ff.cnt >= 7'h20) && (hdr_len != 7'h00)
                     && (rise_ff.cnt >= hdr_len);

   // opcode and address shift in msb first; dummies only bump the count
   always_comb
   begin
      nxt_rise = rise_ff;
      if (rise_ff.cnt < 7'h20)
      begin
         nxt_rise.sh = {rise_ff.sh[30:0], LNK.si}; // [R16] [R17]
      end
      // saturate at the longest header, dummy bit values unused
      if (rise_ff.cnt < flash_rd_pkg::HDR_LEGACY)
      begin
         nxt_rise.cnt = rise_ff.cnt + 7'h01; // [R20]
      end
   end

   // mode 3 first edge is falling, so nothing here depends on it [R18]
   always_ff @(posedge LNK.sck or negedge lnk_rst_n)
   begin
      if (!lnk_rst_n)
      begin
         rise_ff <= '0;
      end
      else
      begin
         rise_ff <= nxt_rise;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data output on the falling edge

   assign start_loc = map_addr(rise_ff.sh[23:0], m264);
   assign cur_loc = '{page: fall_ff.page, byte_ix: fall_ff.byte_ix};
   assign adv_loc = step_addr(cur_loc, m264);

   // first bit goes out on the falling edge after the last header bit;
   // unknown opcodes never start, so the output stays released
   always_comb
   begin
      nxt_fall = fall_ff;
      if (!fall_ff.run)
      begin
         if (hdr_done)
         begin
            nxt_fall.run = 1'b1; // [R1] [R2] [R3] [R4]
            nxt_fall.page = start_loc.page; // [R7]
            nxt_fall.byte_ix = start_loc.byte_ix;
            nxt_fall.so = ARR_DATA_I[7]; // [R17]
            nxt_fall.bitx = 3'h1;
         end
      end
      else
      begin
         nxt_fall.so = ARR_DATA_I[3'h7 - fall_ff.bitx]; // [R8]
         nxt_fall.bitx = fall_ff.bitx + 3'h1;
         if (fall_ff.bitx == 3'h7)
         begin
            // advancing on the last bit avoids any gap cycle [R10]
            nxt_fall.page = adv_loc.page;
            nxt_fall.byte_ix = adv_loc.byte_ix;
         end
      end
   end

   // mode 0 and mode 3 both shift out on the falling edge [R18]
   always_ff @(negedge LNK.sck or negedge lnk_rst_n)
   begin
      if (!lnk_rst_n)
      begin
         fall_ff <= '0;
      end
      else
      begin
         fall_ff <= nxt_fall;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // array read only, no buffer path exists here [R13]
   assign ARR_PAGE_O = fall_ff.run ? fall_ff.page : start_loc.page;
   assign ARR_BYTE_O = fall_ff.run ? fall_ff.byte_ix : start_loc.byte_ix;
   assign READ_ACTIVE_O = fall_ff.run;
   assign LNK.so = fall_ff.so;
   // gated by select directly so release needs no clock edge
   assign LNK.so_oe = fall_ff.run & ~LNK.cs_n; // [R12]
endmodule : flash_rd_dev

//--- logic/flash_rd_host.sv
// host end: issues one continuous array read and collects the bytes
// assumes a system clock well above twice the serial clock it makes
`timescale 1ns/1ns
module flash_rd_host
#(
   parameter int HALF = flash_rd_pkg::HALF_PERIOD
)
(
   flash_link_if.host LNK,
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic START_I,
   input wire logic [7:0] OPCODE_I,
   input wire logic [23:0] ADDR_I,
   input wire logic [12:0] LEN_I,
   output logic [7:0] DATA_O,
   output logic DATA_VLD_O,
   output logic BUSY_O
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_GAP = 3'b100
   } state_t;

   typedef struct packed {
      state_t st;
      logic [7:0] hc;
      logic sck;
      logic cs_n;
      logic si;
      logic [flash_rd_pkg::TX_W-1:0] tx;
      logic [15:0] bitn;
      logic [15:0] total;
      logic [15:0] hdr;
      logic [7:0] rx;
      logic [7:0] data;
      logic vld;
   } host_t;

   host_t s_ff;
   host_t nxt_s;
   logic so_s;
   logic [6:0] op_hdr;

   ////////////////////////////////////////////////////////////////////////
   // serial input crossing; the device drives it off our clock's edges

   sync2 u_so_sync
   (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .d_i(LNK.so_line),
      .q_o(so_s)
   );

   assign op_hdr = flash_rd_pkg::hdr_bits(OPCODE_I);

   ////////////////////////////////////////////////////////////////////////
   // sequencer; mode 0, sck idles low, out on fall, sample on rise

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.vld = 1'b0;
      case (s_ff.st)
         ST_IDLE:
         begin
            // unknown opcodes are refused without touching the link;
            // the legacy opcode is still passed on whenever a caller asks for it [R14]
            if (START_I && (op_hdr != 7'h00))
            begin
               nxt_s.hdr = {9'h000, op_hdr};
               nxt_s.total = {9'h000, op_hdr} + {LEN_I, 3'h0};
               // first opcode bit already on si at select fall
               nxt_s.tx = {OPCODE_I[6:0], ADDR_I, 33'h0}; // [R17]
               nxt_s.si = OPCODE_I[7];
               nxt_s.cs_n = 1'b0; // [R16]
               nxt_s.bitn = '0;
               nxt_s.hc = '0;
               nxt_s.st = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            // one slow rate for every opcode suits the no-dummy read [R15]
            nxt_s.hc = s_ff.hc + 8'h01;
            if (s_ff.hc == 8'(HALF - 1))
            begin
               nxt_s.hc = '0;
               if (!s_ff.sck)
               begin
                  nxt_s.sck = 1'b1;
                  nxt_s.rx = {s_ff.rx[6:0], so_s}; // [R8]
                  nxt_s.bitn = s_ff.bitn + 16'h0001;
                  if ((s_ff.bitn >= s_ff.hdr) && (s_ff.bitn[2:0] == 3'h7))
                  begin
                     nxt_s.data = {s_ff.rx[6:0], so_s};
                     nxt_s.vld = 1'b1;
                  end
               end
               else
               begin
                  nxt_s.sck = 1'b0;
                  nxt_s.si = s_ff.tx[flash_rd_pkg::TX_W-1]; // [R20]
                  nxt_s.tx = {s_ff.tx[flash_rd_pkg::TX_W-2:0], 1'b0};
                  // select stays low until every bit is done [R9]
                  if (s_ff.bitn == s_ff.total)
                  begin
                     nxt_s.cs_n = 1'b1; // [R12]
                     nxt_s.st = ST_GAP;
                  end
               end
            end
         end
         ST_GAP:
         begin
            // select high for a half period before the next command
            nxt_s.hc = s_ff.hc + 8'h01;
            if (s_ff.hc == 8'(HALF - 1))
            begin
               nxt_s.hc = '0;
               nxt_s.st = ST_IDLE;
            end
         end
         default:
         begin
            nxt_s.st = ST_IDLE;
            nxt_s.cs_n = 1'b1;
            nxt_s.sck = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         s_ff <= '{st: ST_IDLE, cs_n: 1'b1, default: '0};
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign LNK.cs_n = s_ff.cs_n;
   assign LNK.sck = s_ff.sck;
   assign LNK.si = s_ff.si;
   assign DATA_O = s_ff.data;
   assign DATA_VLD_O = s_ff.vld;
   assign BUSY_O = (s_ff.st != ST_IDLE);
endmodule : flash_rd_host

//--- tb/flash_rd_monitor.sv
// link checker for the serial array read
// assumes plain copies of the link and the host clock and reset
`timescale 1ns/1ns
module flash_rd_monitor
(
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic so_line
);
   logic [7:0] cnt_ff;
   logic [7:0] op_ff;

   ////////////////////////////////////////////////////////////////////
   // rises since select fell; saturates so long reads stay sane
   always_ff @(posedge sck or posedge cs_n or negedge RST_N_I)
   begin
      if (cs_n || !RST_N_I)
      begin
         cnt_ff <= 8'h00;
         op_ff <= 8'h00;
      end
      else
      begin
         if (cnt_ff != 8'hFF)
            cnt_ff <= cnt_ff + 8'h01;
         if (cnt_ff < 8'h08)
            op_ff <= {op_ff[6:0], si};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output must stay off through the header, then on at once
   property hdr_p(logic [7:0] op, int hdr);
      @(posedge sck) disable iff (cs_n || !RST_N_I)
      (op_ff == op && cnt_ff >= 8'h08) |-> (so_oe == (cnt_ff >= hdr));
   endproperty

   a_legacy_hdr: assert property (hdr_p(flash_rd_pkg::OP_LEGACY, 64))
      else $error("legacy read data timing wrong");
   a_fastest_hdr: assert property (hdr_p(flash_rd_pkg::OP_FASTEST, 48))
      else $error("fastest read data timing wrong");
   a_fast_hdr: assert property (hdr_p(flash_rd_pkg::OP_FAST, 40))
      else $error("fast read data timing wrong");
   a_slow_hdr: assert property (hdr_p(flash_rd_pkg::OP_SLOW, 32))
      else $error("slow read data timing wrong");
   a_quiet_header: assert property (@(posedge sck)
      disable iff (cs_n || !RST_N_I) cnt_ff < 8'h20 |-> !so_oe)
      else $error("output driven during opcode or address");

   ////////////////////////////////////////////////////////////////////
   // system clock view of the wire
   a_idle_clock_low: assert property (@(posedge CLK_SYS_I)
      disable iff (!RST_N_I) cs_n |-> !sck)
      else $error("serial clock not low while deselected");
   a_select_held: assert property (@(posedge CLK_SYS_I)
      disable iff (!RST_N_I) $fell(cs_n) |-> !cs_n [*8])
      else $error("select dropped right after command start");
   a_out_on_fall: assert property (@(posedge CLK_SYS_I)
      disable iff (!RST_N_I)
      (sck && $past(sck) && so_oe && $past(so_oe)) |-> $stable(so))
      else $error("data moved while serial clock high");
   a_release_out: assert property (@(posedge CLK_SYS_I)
      disable iff (!RST_N_I) cs_n |-> !so_oe)
      else $error("output driven while deselected");
   a_line_pulled: assert property (@(posedge CLK_SYS_I)
      disable iff (!RST_N_I) !so_oe |-> so_line)
      else $error("released line not high");

   c_slow: cover property (@(posedge sck)
      op_ff == flash_rd_pkg::OP_SLOW && so_oe);
   c_legacy: cover property (@(posedge sck)
      op_ff == flash_rd_pkg::OP_LEGACY && so_oe);
   c_end: cover property (@(posedge CLK_SYS_I) $rose(cs_n));
endmodule : flash_rd_monitor

//--- tb/tb.sv
// bench: host and device joined on the link, array modelled here
// assumes the host makes the serial clock from the system clock
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [23:0] addr = 24'h000000;
   logic [12:0] len = 13'h0000;
   logic pg264 = 1'b1;
   logic [7:0] data;
   logic vld;
   logic busy;
   logic [10:0] pg;
   logic [8:0] by;
   logic act;
   int failures = 0;
   int checks = 0;

   flash_link_if flash_link_if_i ();

   // pattern differs per page and byte so misaddressing shows
   function automatic logic [7:0] arr_val(input logic [10:0] p,
      input logic [8:0] b);
      return p[7:0] ^ b[7:0] ^ {b[8], p[10:8], 4'h6};
   endfunction : arr_val

   flash_rd_host flash_rd_host_i (.LNK(flash_link_if_i),
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .START_I(start),
      .OPCODE_I(opcode), .ADDR_I(addr), .LEN_I(len), .DATA_O(data),
      .DATA_VLD_O(vld), .BUSY_O(busy));
   flash_rd_dev flash_rd_dev_i (.LNK(flash_link_if_i), .RST_N_I(rst_n),
      .PAGE_264_I(pg264), .ARR_DATA_I(arr_val(pg, by)),
      .ARR_PAGE_O(pg), .ARR_BYTE_O(by), .READ_ACTIVE_O(act));
   flash_rd_monitor mon_i (.CLK_SYS_I(clk), .RST_N_I(rst_n),
      .cs_n(flash_link_if_i.cs_n), .sck(flash_link_if_i.sck),
      .si(flash_link_if_i.si), .so(flash_link_if_i.so),
      .so_oe(flash_link_if_i.so_oe), .so_line(flash_link_if_i.so_line));

   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic check8(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : check8

   task automatic check1(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : check1

   // bounded wait; running out ends the run as a mismatch
   // looks mid-cycle, away from the edge that launches the outputs
   task automatic wait_for(input logic want, input logic on_busy);
      int t;
      logic s;
      t = 0;
      do
      begin
         @(negedge clk);
         t++;
         s = on_busy ? busy : vld;
      end
      while (s !== want && t < 4000);
      if (s !== want)
      begin
         failures++;
         print_verdict();
      end
   endtask : wait_for

   // one read; expected bytes walk the address as the device should
   task automatic run_read(input logic [7:0] op, input logic [23:0] a,
      input logic [12:0] n, input logic m);
      logic [10:0] p;
      logic [8:0] b;
      logic [8:0] last;
      p = m ? a[19:9] : a[18:8];
      b = m ? a[8:0] : {1'b0, a[7:0]};
      last = m ? flash_rd_pkg::LAST_BYTE_264 : flash_rd_pkg::LAST_BYTE_256;
      @(posedge clk);
      pg264 <= m;
      start <= 1'b1;
      opcode <= op;
      addr <= a;
      len <= n;
      @(posedge clk);
      start <= 1'b0;
      for (int k = 0; k < n; k++)
      begin
         wait_for(1'b1, 1'b0);
         check8("data", arr_val(p, b), data);
         check1("active", 1'b1, act);
         if (b >= last)
         begin
            b = 9'h000;
            p = p + 11'h001;
         end
         else
            b = b + 9'h001;
      end
      wait_for(1'b0, 1'b1);
      check1("so_oe", 1'b0, flash_link_if_i.so_oe);
      check1("active", 1'b0, act);
   endtask : run_read

   ////////////////////////////////////////////////////////////////////
   // every opcode across a page end in 264-byte pages
   task automatic test_opcodes;
      logic [7:0] ops [4];
      ops = '{flash_rd_pkg::OP_LEGACY, flash_rd_pkg::OP_FASTEST,
         flash_rd_pkg::OP_FAST, flash_rd_pkg::OP_SLOW};
      foreach (ops[i])
         run_read(ops[i], 24'h000B06, 13'h0003,
            1'b1);
      $display("test opcodes done");
   endtask : test_opcodes

   // array end wrap in both page modes, junk in unused high bits
   task automatic test_wrap;
      run_read(flash_rd_pkg::OP_FAST, 24'hFFFFFE, 13'h0003, 1'b0);
      run_read(flash_rd_pkg::OP_FASTEST, 24'hFFFF07, 13'h0002, 1'b1);
      $display("test wrap done");
   endtask : test_wrap

   // an opcode outside the read set leaves the link idle
   task automatic test_refused;
      @(posedge clk);
      start <= 1'b1;
      opcode <= 8'hD2;
      @(posedge clk);
      start <= 1'b0;
      repeat (40) @(posedge clk);
      check1("busy", 1'b0, busy);
      check1("cs_n", 1'b1, flash_link_if_i.cs_n);
      $display("test refused done");
   endtask : test_refused

   initial
   begin
      forever #5 clk = ~clk;
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      test_opcodes();
      test_wrap();
      test_refused();
      print_verdict();
   end
endmodule : tb
